// ### rtl/txrx_pkg.sv
// txrx_pkg: register map, field layout, reset values, timing
// counts and types of the transmit pattern / IF calibration block.
// assumes a 40 MHz reference clock and an APB host.
package txrx_pkg;
  localparam int CLK_KHZ = 40000;
  localparam int SEQ_TICK_KHZ = 100;
  localparam int SEQ_DIV = CLK_KHZ / SEQ_TICK_KHZ;
  localparam int COARSE_CAL_US = 200;
  localparam int COARSE_CAL_CYC = (COARSE_CAL_US * CLK_KHZ + 999) / 1000;
  localparam int FINE_STEPS = 10;
  localparam int LAT_DEPTH = 5;
  localparam int RSSI_LEVELS = 80;

  localparam logic [7:0] ADDR_TX_CTRL = 8'h00;
  localparam logic [7:0] ADDR_RX_CFG = 8'h04;
  localparam logic [7:0] ADDR_COARSE = 8'h08;
  localparam logic [7:0] ADDR_FINE = 8'h0C;
  localparam logic [7:0] ADDR_DWELL = 8'h10;
  localparam logic [7:0] ADDR_SYNC = 8'h14;
  localparam logic [7:0] ADDR_STATUS = 8'h18;

  localparam int CO_EN_BIT = 4;
  localparam int CO_DIV_LSB = 5;
  localparam int FI_EN_BIT = 4;
  localparam int FI_LO_LSB = 5;
  localparam int FI_HI_LSB = 13;

  localparam logic [2:0] MOD_2FSK = 3'h0;
  localparam logic [2:0] MOD_GFSK = 3'h1;
  localparam logic [2:0] PAT_NORMAL = 3'h0;
  localparam logic [2:0] PAT_CARRIER = 3'h1;
  localparam logic [2:0] PAT_PLUS = 3'h2;
  localparam logic [2:0] PAT_MINUS = 3'h3;
  localparam logic [2:0] PAT_ALT = 3'h4;
  localparam logic [2:0] PAT_PN9 = 3'h5;
  localparam logic [2:0] PAT_SYNC = 3'h6;
  localparam logic [1:0] DRV_DATA = 2'h0;
  localparam logic [1:0] DRV_CARRIER = 2'h1;
  localparam logic [1:0] DRV_PLUS = 2'h2;
  localparam logic [1:0] DRV_MINUS = 2'h3;

  localparam logic [8:0] TX_CFG_RST = 9'h001;
  localparam logic [8:0] RX_CFG_RST = 9'h100;
  localparam logic [15:0] DWELL_RST = 16'h0032;
  localparam logic [15:0] SYNC_RST = 16'hA5C3;
  localparam logic [8:0] PN9_SEED = 9'h1FF;
  localparam logic [6:0] AGC_HIGH = 7'h46;
  localparam logic [6:0] AGC_LOW = 7'h1E;
  localparam logic [2:0] AGC_TOP = 3'h4;
  localparam logic [6:0] TRIM_TOL = 7'h01;
  localparam logic [5:0] TRIM_MID = 6'h20;

  typedef struct packed {
    logic [2:0] pattern;
    logic alpha07;
    logic [2:0] mod;
    logic clk_inv;
    logic tx_rx;
  } tx_cfg_t;

  typedef struct packed {
    logic agc_en;
    logic [1:0] if_gain;
    logic [1:0] bw;
    logic [1:0] amp_gain;
    logic mixer_lin;
    logic amp_mode;
  } rx_cfg_t;

  typedef struct packed {
    logic [2:0] agc_level;
    logic [6:0] rssi;
    logic [5:0] trim;
    logic [3:0] step;
    logic fine;
    logic busy;
  } status_t;

  typedef enum logic [1:0] {CAL_IDLE, CAL_COARSE, CAL_FINE} cal_state_t;
endpackage : txrx_pkg

// ### rtl/txrx_pattern_ifcal_ctrl.sv
// txrx_pattern_ifcal_ctrl: transmit latency line and test patterns,
// receive front-end settings, IF filter calibration, flash RSSI, AGC.
// assumes an APB master on i_ref_clk; link pins are asynchronous.
`timescale 1ns/1ps
module txrx_pattern_ifcal_ctrl
  import txrx_pkg::*;
#(
  parameter int unsigned COARSE_CYCLES = COARSE_CAL_CYC
)
(
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_sys_rst,
  // apb slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic o_pready,
  output logic o_pslverr,
  output logic [31:0] o_prdata,
  // transmit link
  input wire logic i_data_exchange_clock,
  input wire logic i_tx_data,
  output logic o_tx_bit,
  output logic [1:0] o_tx_drive,
  // receive front end
  input wire logic [79:0] i_rssi_comp,
  output logic o_lna_short,
  output logic o_front_amp_operating_mode,
  output logic o_mixer_linearity,
  output logic [1:0] o_front_amp_gain_setting,
  output logic [1:0] o_if_bandwidth,
  output logic [1:0] o_if_gain,
  // calibration
  output logic o_amp_detach,
  output logic o_tone_inject,
  output logic o_tone_upper,
  output logic o_coarse_cal_run,
  output logic [5:0] o_filter_trim,
  output logic [8:0] o_cal_ref_divider,
  output logic [7:0] o_tone_low_divider,
  output logic [7:0] o_tone_high_divider,
  output logic [6:0] o_rssi_code
);

  function automatic logic [2:0] lat_bits(input logic [2:0] m,
                                          input logic a7);
    logic [2:0] n;
    n = 3'h1;
    if (m == MOD_GFSK)
      n = 3'h4;
    else if (m[2] && (m[1:0] != 2'h0))
      n = a7 ? 3'h4 : 3'h5;
    return n;
  endfunction : lat_bits

  function automatic logic [6:0] flash_count(input logic [79:0] c);
    logic [6:0] n;
    n = 7'h00;
    for (int k = 0; k < RSSI_LEVELS; k++)
      n = n + {6'h00, c[k]};
    return n;
  endfunction : flash_count

  // agc level to {amp gain, if gain}; 4 is highest gain
  function automatic logic [3:0] gain_map(input logic [2:0] lv);
    logic [3:0] g;
    case (lv)
      3'h4: g = 4'hA;
      3'h3: g = 4'h6;
      3'h2: g = 4'h5;
      3'h1: g = 4'h4;
      default: g = 4'h0;
    endcase
    return g;
  endfunction : gain_map

  function automatic logic addr_ok(input logic [7:0] a);
    return (a <= ADDR_STATUS) && (a[1:0] == 2'h0);
  endfunction : addr_ok

  tx_cfg_t tx_cfg_reg;
  rx_cfg_t rx_cfg_reg;
  status_t status;
  cal_state_t cal_state_reg;
  logic coarse_en_reg;
  logic [8:0] cal_div_reg;
  logic fine_en_reg;
  logic [7:0] tone_lo_reg;
  logic [7:0] tone_hi_reg;
  logic [15:0] dwell_reg;
  logic [15:0] sync_word_reg;
  logic [2:0] clk_sync_reg;
  logic [1:0] dat_sync_reg;
  logic [79:0] comp_meta_reg;
  logic [79:0] comp_reg;
  logic [LAT_DEPTH-1:0] lat_sr_reg;
  logic [8:0] pn9_reg;
  logic alt_reg;
  logic [15:0] sync_sh_reg;
  logic [15:0] cyc_cnt_reg;
  logic [8:0] seq_cnt_reg;
  logic seq_tick;
  logic [15:0] dwell_cnt_reg;
  logic [3:0] step_reg;
  logic [5:0] trim_reg;
  logic [6:0] meas_lo_reg;
  logic [2:0] agc_level_reg;
  logic [6:0] rssi_reg;
  logic [31:0] rd_mux;
  logic wr;
  logic rise_edge;
  logic fall_edge;
  logic sample_edge;
  logic src_bit;
  logic step_end;
  logic [2:0] lat;
  logic [6:0] diff;
  logic [3:0] agc_gain;
  logic inv_hold_reg;

  // apb: zero wait states, error on unmapped address
  assign o_pready = 1'b1;
  assign o_pslverr = i_psel && i_penable && !addr_ok(i_paddr);
  assign wr = i_psel && i_penable && i_pwrite && addr_ok(i_paddr);

  always_ff @(posedge i_ref_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      tx_cfg_reg <= TX_CFG_RST;
      rx_cfg_reg <= RX_CFG_RST;
      coarse_en_reg <= 1'b0;
      cal_div_reg <= 9'h000;
      fine_en_reg <= 1'b0;
      tone_lo_reg <= 8'h00;
      tone_hi_reg <= 8'h00;
      dwell_reg <= DWELL_RST;
      sync_word_reg <= SYNC_RST;
    end
    else if (wr)
    begin
      case (i_paddr)
        ADDR_TX_CTRL: tx_cfg_reg <= i_pwdata[8:0];
        ADDR_RX_CFG: rx_cfg_reg <= i_pwdata[8:0];
        ADDR_COARSE:
        begin
          coarse_en_reg <= i_pwdata[CO_EN_BIT];
          cal_div_reg <= i_pwdata[CO_DIV_LSB +: 9];
        end
        ADDR_FINE:
        begin
          fine_en_reg <= i_pwdata[FI_EN_BIT];
          tone_lo_reg <= i_pwdata[FI_LO_LSB +: 8];
          tone_hi_reg <= i_pwdata[FI_HI_LSB +: 8];
        end
        ADDR_DWELL: dwell_reg <= i_pwdata[15:0];
        ADDR_SYNC: sync_word_reg <= i_pwdata[15:0];
        default: ;
      endcase
    end
  end

  assign status = '{agc_level: agc_level_reg, rssi: rssi_reg,
                    trim: trim_reg, step: step_reg,
                    fine: cal_state_reg == CAL_FINE,
                    busy: cal_state_reg != CAL_IDLE};

  always_comb
  begin
    rd_mux = 32'h00000000;
    case (i_paddr)
      ADDR_TX_CTRL: rd_mux[8:0] = tx_cfg_reg;
      ADDR_RX_CFG: rd_mux[8:0] = rx_cfg_reg;
      ADDR_COARSE:
      begin
        rd_mux[CO_EN_BIT] = coarse_en_reg;
        rd_mux[CO_DIV_LSB +: 9] = cal_div_reg;
      end
      ADDR_FINE:
      begin
        rd_mux[FI_EN_BIT] = fine_en_reg;
        rd_mux[FI_LO_LSB +: 8] = tone_lo_reg;
        rd_mux[FI_HI_LSB +: 8] = tone_hi_reg;
      end
      ADDR_DWELL: rd_mux[15:0] = dwell_reg;
      ADDR_SYNC: rd_mux[15:0] = sync_word_reg;
      ADDR_STATUS: rd_mux[21:0] = status;
      default: rd_mux = 32'h00000000;
    endcase
  end

  // read data latched in the setup phase, valid in the access phase
  always_ff @(posedge i_ref_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
      o_prdata <= 32'h00000000;
    else if (i_psel && !i_penable && !i_pwrite)
      o_prdata <= rd_mux;
  end

  // pin synchronisers; the first stage feeds only the second
  always_ff @(posedge i_ref_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      clk_sync_reg <= 3'h0;
      dat_sync_reg <= 2'h0;
      comp_meta_reg <= '0;
      comp_reg <= '0;
    end
    else
    begin
      clk_sync_reg <= {clk_sync_reg[1:0], i_data_exchange_clock};
      dat_sync_reg <= {dat_sync_reg[0], i_tx_data};
      comp_meta_reg <= i_rssi_comp;
      comp_reg <= comp_meta_reg;
    end
  end

  assign rise_edge = clk_sync_reg[1] && !clk_sync_reg[2];
  assign fall_edge = !clk_sync_reg[1] && clk_sync_reg[2];
  assign sample_edge = tx_cfg_reg.clk_inv ? fall_edge : rise_edge;
  assign lat = lat_bits(tx_cfg_reg.mod, tx_cfg_reg.alpha07);

  always_comb
  begin
    case (tx_cfg_reg.pattern)
      PAT_ALT: src_bit = alt_reg;
      PAT_PN9: src_bit = pn9_reg[8];
      PAT_SYNC: src_bit = sync_sh_reg[15];
      default: src_bit = dat_sync_reg[1];
    endcase
  end

  // pattern generators step only on sampling edges, so at data rate
  always_ff @(posedge i_ref_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      pn9_reg <= PN9_SEED;
      alt_reg <= 1'b1;
      sync_sh_reg <= SYNC_RST;
    end
    else if (sample_edge)
    begin
      pn9_reg <= {pn9_reg[7:0], pn9_reg[8] ^ pn9_reg[4]};
      alt_reg <= !alt_reg;
      if (tx_cfg_reg.pattern == PAT_SYNC)
        sync_sh_reg <= {sync_sh_reg[14:0], sync_sh_reg[15]};
      else
        sync_sh_reg <= sync_word_reg;
    end
  end

  // output taps the old line value, so at latency 1 a bit sampled on one rising
  // edge leaves on the next; falling-edge sampling adds half a bit
  always_ff @(posedge i_ref_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      lat_sr_reg <= '0;
      inv_hold_reg <= 1'b0;
      o_tx_bit <= 1'b0;
      o_tx_drive <= DRV_DATA;
    end
    else
    begin
      // inverted clock: the falling-edge sample waits for the next
      // rise, which is where the extra half bit comes from
      if (fall_edge)
        inv_hold_reg <= src_bit;
      if (rise_edge)
        lat_sr_reg <= {lat_sr_reg[LAT_DEPTH-2:0],
                       tx_cfg_reg.clk_inv ? inv_hold_reg : src_bit};
      if (rise_edge)
        o_tx_bit <= lat_sr_reg[lat - 3'h1];
      case (tx_cfg_reg.pattern)
        PAT_CARRIER: o_tx_drive <= DRV_CARRIER;
        PAT_PLUS: o_tx_drive <= DRV_PLUS;
        PAT_MINUS: o_tx_drive <= DRV_MINUS;
        default: o_tx_drive <= DRV_DATA;
      endcase
    end
  end

  // sequencer tick from the reference clock
  always_ff @(posedge i_ref_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
      seq_cnt_reg <= 9'h000;
    else if (seq_tick)
      seq_cnt_reg <= 9'h000;
    else
      seq_cnt_reg <= seq_cnt_reg + 9'h001;
  end
  assign seq_tick = seq_cnt_reg == 9'(SEQ_DIV - 1);

  assign step_end = (cal_state_reg == CAL_FINE) && seq_tick &&
                    (dwell_cnt_reg + 16'h0001 >= dwell_reg);
  assign diff = (meas_lo_reg > rssi_reg) ? meas_lo_reg - rssi_reg
                                         : rssi_reg - meas_lo_reg;

  // calibration runs by itself once started; a busy flag is readable
  always_ff @(posedge i_ref_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      cal_state_reg <= CAL_IDLE;
      cyc_cnt_reg <= 16'h0000;
      dwell_cnt_reg <= 16'h0000;
      step_reg <= 4'h0;
      trim_reg <= TRIM_MID;
      meas_lo_reg <= 7'h00;
    end
    else
    begin
      case (cal_state_reg)
        CAL_IDLE:
        begin
          cyc_cnt_reg <= 16'h0000;
          dwell_cnt_reg <= 16'h0000;
          step_reg <= 4'h0;
          if (wr && i_paddr == ADDR_COARSE)
          begin
            if (i_pwdata[CO_EN_BIT])
              cal_state_reg <= CAL_COARSE;
            else if (fine_en_reg)
              cal_state_reg <= CAL_FINE;
          end
        end
        CAL_COARSE:
        begin
          cyc_cnt_reg <= cyc_cnt_reg + 16'h0001;
          if (cyc_cnt_reg == 16'(COARSE_CYCLES - 1))
          begin
            trim_reg <= TRIM_MID;
            cal_state_reg <= fine_en_reg ? CAL_FINE : CAL_IDLE;
          end
        end
        CAL_FINE:
        begin
          if (step_end)
          begin
            dwell_cnt_reg <= 16'h0000;
            step_reg <= step_reg + 4'h1;
            if (!step_reg[0])
              meas_lo_reg <= rssi_reg;
            else if (diff <= TRIM_TOL ||
                     step_reg == 4'(FINE_STEPS - 1))
              cal_state_reg <= CAL_IDLE;
            else if (meas_lo_reg > rssi_reg)
              trim_reg <= trim_reg - 6'h01;
            else
              trim_reg <= trim_reg + 6'h01;
          end
          else if (seq_tick)
            dwell_cnt_reg <= dwell_cnt_reg + 16'h0001;
        end
        default: cal_state_reg <= CAL_IDLE;
      endcase
    end
  end

  // flash conversion every cycle, gain control stepping on sequencer ticks
  always_ff @(posedge i_ref_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      rssi_reg <= 7'h00;
      agc_level_reg <= AGC_TOP;
    end
    else
    begin
      rssi_reg <= flash_count(comp_reg);
      if (rx_cfg_reg.agc_en && tx_cfg_reg.tx_rx && seq_tick &&
          cal_state_reg == CAL_IDLE)
      begin
        if (rssi_reg > AGC_HIGH && agc_level_reg != 3'h0)
          agc_level_reg <= agc_level_reg - 3'h1;
        else if (rssi_reg < AGC_LOW && agc_level_reg != AGC_TOP)
          agc_level_reg <= agc_level_reg + 3'h1;
      end
    end
  end

  assign o_lna_short = !tx_cfg_reg.tx_rx;
  assign o_front_amp_operating_mode = rx_cfg_reg.amp_mode;
  assign o_mixer_linearity = rx_cfg_reg.mixer_lin;
  assign agc_gain = gain_map(agc_level_reg);
  assign o_front_amp_gain_setting = rx_cfg_reg.agc_en ?
    agc_gain[3:2] : rx_cfg_reg.amp_gain;
  assign o_if_gain = rx_cfg_reg.agc_en ?
    agc_gain[1:0] : rx_cfg_reg.if_gain;
  assign o_if_bandwidth = rx_cfg_reg.bw;
  assign o_amp_detach = cal_state_reg == CAL_FINE;
  assign o_tone_inject = cal_state_reg == CAL_FINE;
  assign o_tone_upper = step_reg[0];
  assign o_coarse_cal_run = cal_state_reg == CAL_COARSE;
  assign o_filter_trim = trim_reg;
  assign o_cal_ref_divider = cal_div_reg;
  assign o_tone_low_divider = tone_lo_reg;
  assign o_tone_high_divider = tone_hi_reg;
  assign o_rssi_code = rssi_reg;

  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (i_sys_rst);

  sequence wr_tx_s;
    wr && i_paddr == ADDR_TX_CTRL && !i_pwdata[0];
  endsequence
  sequence fine_start_s;
    cal_state_reg == CAL_IDLE && wr && i_paddr == ADDR_COARSE &&
    !i_pwdata[CO_EN_BIT] && fine_en_reg;
  endsequence

  lna_short_a: assert property (wr_tx_s |=> o_lna_short)
    else $error("amplifier input not shorted in transmit");
  fine_start_a: assert property (fine_start_s |=> o_amp_detach)
    else $error("coarse register write did not start fine cal");
  coarse_len_a: assert property ($fell(o_coarse_cal_run) |->
    $past(cyc_cnt_reg) == 16'(COARSE_CYCLES - 1))
    else $error("coarse calibration length wrong");
  fine_max_a: assert property (o_amp_detach |->
    step_reg < 4'(FINE_STEPS))
    else $error("fine calibration exceeded ten steps");
  manual_gain_a: assert property (!rx_cfg_reg.agc_en |->
    o_front_amp_gain_setting == rx_cfg_reg.amp_gain)
    else $error("manual amplifier gain not applied");
  pn9_live_a: assert property (pn9_reg != 9'h000)
    else $error("pn9 register locked at zero");
  alt_rate_a: assert property (!sample_edge |=> $stable(alt_reg))
    else $error("pattern advanced without a sampling edge");
  lat_one_a: assert property (rise_edge && lat == 3'h1 |=>
    o_tx_bit == $past(lat_sr_reg[0]))
    else $error("unfiltered latency not one bit");
  unmapped_a: assert property (i_psel && i_penable &&
    i_paddr > ADDR_STATUS |-> o_pslverr)
    else $error("unmapped access not flagged");

endmodule : txrx_pattern_ifcal_ctrl

// ### testbench/host_link_model.sv
// host_link_model: host end of the transmit link plus the RSSI
// comparator bank that the block reads during calibration.
// assumes the bench sets the next bit after each data clock rise.
`timescale 1ns/1ps
module host_link_model
(
  // bench control
  input wire logic i_run,
  input wire logic i_next_bit,
  input wire logic [6:0] i_level,
  // block outputs watched
  input wire logic i_amp_detach,
  input wire logic i_tone_upper,
  input wire logic [5:0] i_filter_trim,
  // pins into the block
  output logic o_dclk,
  output logic o_data,
  output logic [79:0] o_comp
);
  int n;

  // data moves mid-low so both edges see it settled
  initial
  begin
    o_dclk = 1'b0;
    o_data = 1'b0;
    forever
    begin
      #100;
      o_dclk = 1'b0;
      #50;
      // idle line toggles, so a stale bit cannot pass for data
      o_data = i_run ? i_next_bit : ~o_data;
      #50;
      o_dclk = i_run;
    end
  end

  // mistuned filter: tone levels balance only at trim 29
  always_comb
  begin
    n = int'(i_level);
    if (i_amp_detach)
      n = i_tone_upper ? 98 - 2 * int'(i_filter_trim)
                       : 2 * int'(i_filter_trim) - 18;
    o_comp = ~({80{1'b1}} << n);
  end
endmodule : host_link_model

// ### testbench/tb.sv
// tb: drives txrx_pattern_ifcal_ctrl over APB and the transmit link,
// checking latency, patterns, front end, calibration and gain control.
// assumes host_link_model on the far side and a short coarse count.
`timescale 1ns/1ps
module tb;
  import txrx_pkg::*;
  localparam int unsigned CO = 20;
  // crystal behind the filter dividers, apart from the logic clock
  localparam int XTAL_KHZ = 12800;
  localparam logic [8:0] REF_DIV = 9'(XTAL_KHZ / 50);
  localparam logic [7:0] LO_DIV = 8'((XTAL_KHZ * 5 + 329) / 658);
  localparam logic [7:0] HI_DIV = 8'((XTAL_KHZ + 131) / 263);
  localparam logic [31:0] TONES = {11'h0, HI_DIV, LO_DIV, 5'h00};
  localparam logic [31:0] COARSE_GO = {18'h0, REF_DIV, 5'h10};
  logic clk, rst, psel, pen, pwr, run, nbit, inv;
  logic [7:0] addr;
  logic [31:0] wdata, lf, rv, dd, w, prdata;
  logic [6:0] lvl, rssi;
  logic pready, pslverr, tx_bit, lna_short, amp_mode, mix_lin, detach;
  logic inject, upper, crun, dclk, dtx;
  logic [1:0] tx_drive, again, bw, igain;
  logic [5:0] trim;
  logic [8:0] refdiv;
  logic [7:0] lodiv, hidiv;
  logic [79:0] comp;
  int fails, checks_done, lat, cyc, c, bad, e0, e1, e2, e3, ok;
  logic [31:0] rq[$];
  logic eq[$], bq[$], obs[$];
  logic [8:0] cfg[9] = '{9'h000, 9'h004, 9'h014, 9'h034, 9'h03C,
                         9'h018, 9'h00A, 9'h00C, 9'h01E};
  int lt[9] = '{1, 4, 5, 4, 4, 5, 1, 1, 5};

  txrx_pattern_ifcal_ctrl #(.COARSE_CYCLES(CO)) i_txrx_pattern_ifcal_ctrl
  (
    .i_ref_clk(clk), .i_sys_rst(rst), .i_psel(psel), .i_penable(pen),
    .i_pwrite(pwr), .i_paddr(addr), .i_pwdata(wdata), .o_pready(pready),
    .o_pslverr(pslverr), .o_prdata(prdata),
    .i_data_exchange_clock(dclk), .i_tx_data(dtx), .o_tx_bit(tx_bit),
    .o_tx_drive(tx_drive), .i_rssi_comp(comp), .o_lna_short(lna_short),
    .o_front_amp_operating_mode(amp_mode), .o_mixer_linearity(mix_lin),
    .o_front_amp_gain_setting(again), .o_if_bandwidth(bw),
    .o_if_gain(igain), .o_amp_detach(detach), .o_tone_inject(inject),
    .o_tone_upper(upper), .o_coarse_cal_run(crun),
    .o_filter_trim(trim), .o_cal_ref_divider(refdiv),
    .o_tone_low_divider(lodiv), .o_tone_high_divider(hidiv),
    .o_rssi_code(rssi)
  );

  host_link_model i_host_link_model
  (
    .i_run(run), .i_next_bit(nbit), .i_level(lvl), .i_amp_detach(detach),
    .i_tone_upper(upper), .i_filter_trim(trim), .o_dclk(dclk),
    .o_data(dtx), .o_comp(comp)
  );

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  task automatic chk(input string nm, input logic [31:0] seen,
                     input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      fails++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : wrap_up

  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d, input logic [31:0] e,
                     input logic err);
    @(posedge clk);
    psel <= 1'b1;
    pwr <= wr;
    addr <= a;
    wdata <= d;
    if (!wr)
      rq.push_back(e);
    eq.push_back(err);
    @(posedge clk);
    pen <= 1'b1;
    do
    begin
      @(posedge clk);
    end
    while (pready !== 1'b1);
    psel <= 1'b0;
    pen <= 1'b0;
  endtask : apb

  // link stopped while the mode changes, so no bit straddles it
  task automatic phase(input logic [8:0] cf, input int l, input int n);
    @(posedge clk);
    run <= 1'b0;
    repeat (20) @(posedge clk);
    apb(1'b1, ADDR_TX_CTRL, {23'h0, cf}, 32'h0, 1'b0);
    bq.delete();
    obs.delete();
    lat = l;
    inv = cf[1];
    @(posedge clk);
    run <= 1'b1;
    repeat (n) @(posedge dclk);
    // let the watcher store the last bit before anyone reads it
    @(negedge clk);
  endtask : phase

  task automatic count(input logic s);
    int t;
    t = 0;
    c = 0;
    bad = 0;
    while ((s ? crun : detach) !== 1'b1 && t < 300)
    begin
      @(negedge clk);
      t++;
    end
    while ((s ? crun : detach) === 1'b1 && c < 5000)
    begin
      c++;
      bad += (inject !== detach);
      @(negedge clk);
    end
  endtask : count

  always @(posedge clk)
    if (psel && pen && pready === 1'b1)
    begin
      if (!pwr)
        chk("prdata", prdata, rq.pop_front());
      chk("pslverr", pslverr, eq.pop_front());
    end

  always @(negedge dclk)
    bq.push_back(dtx);

  always @(posedge dclk)
  begin
    if (lat == 0)
      obs.push_back(tx_bit);
    else if (bq.size() > lat + inv)
      chk("tx_bit", tx_bit,
          bq.pop_front());
    nbit <= lf[0];
    lf <= lfsr(lf);
  end

  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 40000)
    begin
      fails++;
      wrap_up();
    end
  end

  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  initial
  begin
    rst = 1'b1;
    psel = 1'b0;
    pen = 1'b0;
    pwr = 1'b0;
    addr = 8'h00;
    wdata = 32'h0;
    run = 1'b0;
    nbit = 1'b0;
    inv = 1'b0;
    lvl = 7'h28;
    lf = 32'hE3FD794A;
    rv = 32'hE3FD794A;
    lat = 1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    chk("lna_short", lna_short, 1'b0);
    apb(1'b0, ADDR_TX_CTRL, 32'h0, TX_CFG_RST, 1'b0);
    apb(1'b0, ADDR_RX_CFG, 32'h0, RX_CFG_RST, 1'b0);
    apb(1'b0, ADDR_DWELL, 32'h0, DWELL_RST, 1'b0);
    apb(1'b0, ADDR_SYNC, 32'h0, SYNC_RST, 1'b0);
    apb(1'b0, 8'h1C, 32'h0, 32'h0, 1'b1);
    apb(1'b1, 8'h1C, 32'h1, 32'h0, 1'b1);
    $display("register reset test done");
    lvl <= 7'h50;
    repeat (2200) @(posedge clk);
    @(negedge clk);
    chk("rssi", rssi, 7'h50);
    chk("agc_amp", again, 2'h0);
    chk("agc_if", igain, 2'h0);
    // weak signal walks the gain back up to the top level
    lvl <= 7'h0A;
    repeat (2200) @(posedge clk);
    @(negedge clk);
    chk("agc_amp_up", again, 2'h2);
    chk("agc_if_up", igain, 2'h2);
    $display("gain control test done");
    rv = lfsr(rv);
    apb(1'b1, ADDR_RX_CFG, {24'h0, rv[7:0]}, 32'h0, 1'b0);
    @(negedge clk);
    chk("amp_mode", amp_mode, rv[0]);
    chk("mixer", mix_lin, rv[1]);
    chk("amp_gain", again, rv[3:2]);
    chk("bw", bw, rv[5:4]);
    chk("if_gain", igain, rv[7:6]);
    apb(1'b0, ADDR_RX_CFG, 32'h0, {24'h0, rv[7:0]}, 1'b0);
    $display("front end test done");
    for (int i = 0; i < 9; i++)
    begin
      phase(cfg[i], lt[i], 24);
      $display("latency case %0d done", i);
    end
    chk("lna_short", lna_short, 1'b1);
    rv = lfsr(rv);
    apb(1'b1, ADDR_SYNC, {16'h0, rv[15:0]}, 32'h0, 1'b0);
    dd = {rv[15:0], rv[15:0]};
    for (int p = 0; p < 7; p++)
    begin
      phase({p[2:0], 6'h00}, 0, 40);
      chk("tx_drive", tx_drive, (p > 0 && p < 4) ? p : 0);
      e0 = 0;
      e1 = 0;
      e2 = 0;
      e3 = 0;
      ok = 0;
      w = 32'h0;
      // first bits skipped: they still carry the previous source
      for (int k = 8; k < 31; k++)
      begin
        e0 += (obs[k] === obs[k + 1]);
        e1 += (obs[k + 9] !== (obs[k + 5] ^ obs[k]));
        e2 += (obs[k + 9] !== (obs[k + 4] ^ obs[k]));
        if (k < 24)
        begin
          e3 += (obs[k] !== obs[k + 16]);
          w = {w[30:0], obs[k]};
        end
      end
      for (int r = 0; r < 16; r++)
        ok += (w[15:0] === dd[31 - r -: 16]);
      if (p == 4)
        chk("alternate", e0, 0);
      if (p == 5)
        chk("pn9", e1 * e2, 0);
      if (p == 6)
        chk("sync", e3 == 0 && ok > 0, 1'b1);
      $display("pattern %0d done", p);
    end
    apb(1'b1, ADDR_DWELL, 32'h1, 32'h0, 1'b0);
    apb(1'b1, ADDR_FINE, TONES, 32'h0, 1'b0);
    apb(1'b1, ADDR_COARSE, COARSE_GO, 32'h0, 1'b0);
    count(1'b1);
    chk("coarse_len", c, CO);
    chk("ref_div", refdiv, REF_DIV);
    chk("no_fine", detach, 1'b0);
    apb(1'b1, ADDR_FINE, TONES | 32'h10, 32'h0, 1'b0);
    @(negedge clk);
    chk("tone_lo", lodiv, LO_DIV);
    chk("tone_hi", hidiv, HI_DIV);
    apb(1'b1, ADDR_COARSE, COARSE_GO, 32'h0, 1'b0);
    count(1'b1);
    chk("coarse_len", c, CO);
    count(1'b0);
    chk("fine_len", c > 2800 && c <= 3210, 1'b1);
    chk("tone_inject", bad, 0);
    chk("trim", trim, 6'h1D);
    apb(1'b1, ADDR_COARSE, COARSE_GO & ~32'h10, 32'h0, 1'b0);
    count(1'b0);
    chk("refine_len", c > 0 && c <= 810, 1'b1);
    chk("trim", trim, 6'h1D);
    $display("calibration test done");
    wrap_up();
  end
endmodule : tb
